// >>> verilog/sdu_bit_sampler.sv
// shared constants and types of the debug port, plus the per-bit majority sampler
package sdu_pkg;
    // ----------------------------------------------------------------------
    // line framing and sampling
    // ----------------------------------------------------------------------
    localparam int SAMPLES_PER_BIT = 16;
    localparam int PHASE_W         = 4;
    localparam int VOTE_A          = 6;    // sample 7, counted from one
    localparam int VOTE_B          = 7;    // sample 8
    localparam int VOTE_C          = 8;    // sample 9
    localparam int FRAME_BITS      = 12;   // start, 8 data, parity, 2 stop
    localparam int BIT_IDX_W       = 4;
    localparam int SYNC_FALLS      = 4;    // falls after the start edge of 0x55
    localparam int SYNC_BITS       = 8;    // start edge to last fall
    localparam int FRAC_STEP       = SAMPLES_PER_BIT * SYNC_BITS;
    localparam int SYNC_TAIL_TICKS = 40;   // from last fall into first stop
    localparam int SYNC_TAIL_W     = 6;
    // ----------------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_DIRECT_LOAD, OP_INDIRECT_LOAD, OP_DIRECT_STORE, OP_INDIRECT_STORE,
        OP_CTRL_STATUS_LOAD, OP_REPEAT, OP_CTRL_STATUS_STORE, OP_KEY
    } sdu_opcode_t;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_RSV2, SZ_RSV3} sdu_size_t;
    typedef enum logic [1:0] {PTR_DEREF, PTR_DEREF_INC, PTR_SELF, PTR_RSV} sdu_ptr_t;
    typedef enum logic [1:0] {KEY_64, KEY_128, KEY_RSV2, KEY_RSV3} sdu_key_size_t;
    localparam logic [3:0] CS_LAST_DIRECT  = 4'h3;
    localparam logic [3:0] CS_ACCESS_LAYER = 4'h4;
    localparam logic [3:0] CS_RESERVED     = 4'hf;
    localparam logic [7:0] KEY_BYTES_64    = 8'h08;
    localparam logic [7:0] KEY_BYTES_128   = 8'h10;
    typedef struct packed {
        sdu_opcode_t   opcode;
        sdu_size_t     size_a;
        sdu_ptr_t      ptr;
        sdu_size_t     size_b;
        logic [3:0]    cs_addr;
        logic          cs_access_layer;
        sdu_key_size_t key_size;
        logic [7:0]    key_bytes;
        logic          sib_send;
        logic          reserved;
    } sdu_instr_t;
    // ----------------------------------------------------------------------
    // debug clock select
    // ----------------------------------------------------------------------
    localparam logic [1:0] CLKSEL_16MHZ = 2'h1;
    localparam logic [1:0] CLKSEL_8MHZ  = 2'h2;
    localparam logic [1:0] CLKSEL_4MHZ  = 2'h3;
    localparam logic [1:0] CLKSEL_RESET = CLKSEL_4MHZ;
    localparam logic [7:0] MHZ_16       = 8'h10;
    localparam logic [7:0] MHZ_8        = 8'h08;
    localparam logic [7:0] MHZ_4        = 8'h04;
endpackage : sdu_pkg

`timescale 1ns/100ps
module sdu_bit_sampler
    import sdu_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic restart_in,
    input  wire logic tick_in,
    input  wire logic line_in,
    output logic      bit_out,
    output logic      done_out
);
    logic [PHASE_W-1:0] phase_r;
    logic [2:0]         vote_r;

    // ----------------------------------------------------------------------
    // sixteen samples per bit, vote on the middle three
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_r  <= 4'h0;
            vote_r   <= 3'h0;
            bit_out  <= 1'b1;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (restart_in) begin
                phase_r <= 4'h0;
            end else if (tick_in) begin
                phase_r <= phase_r + 4'h1;
                if (phase_r == PHASE_W'(VOTE_A)) vote_r[0] <= line_in;
                if (phase_r == PHASE_W'(VOTE_B)) vote_r[1] <= line_in;
                if (phase_r == PHASE_W'(VOTE_C)) vote_r[2] <= line_in;
                // decide right after the third vote, so the next start edge is not missed
                if (phase_r == PHASE_W'(VOTE_C + 1)) begin
                    bit_out  <= (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2])
                              | (vote_r[1] & vote_r[2]);
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule : sdu_bit_sampler

// >>> verilog/sdu_port.sv
// one-wire debug port: auto-baud receive, majority sampling, transmit, decode
`timescale 1ns/100ps
module sdu_port
    import sdu_pkg::*;
#(
    parameter int          PER_W     = 24,
    parameter logic [31:0] BREAK_CYC = 32'd20000000
)(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       line_in,
    output logic            line_out,
    output logic            line_oe_n_out,
    input  wire logic       clk_sel_wr_in,
    input  wire logic [1:0] clk_sel_in,
    input  wire logic       resync_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_error_out,
    output logic            instr_valid_out,
    output sdu_instr_t      instr_out,
    output logic            sib_req_out,
    output logic            baud_locked_out,
    output logic [PER_W-1:0] baud_period_out,
    output logic [1:0]      debug_clock_select_out,
    output logic [7:0]      debug_clock_mhz_out,
    output logic            break_out
);
    typedef enum {ST_SYNC, ST_SYNC_MEAS, ST_SYNC_TAIL, ST_IDLE, ST_RX, ST_TX} sdu_state_t;

    sdu_state_t               state_r;
    logic [2:0]               sync_r;
    logic                     line_f_r;
    logic [PER_W-1:0]         meas_r, period_r, acc_r;
    logic [2:0]               falls_r;
    logic [SYNC_TAIL_W-1:0]   tail_r;
    logic [31:0]              low_r;
    logic [BIT_IDX_W-1:0]     bit_idx_r;
    logic [PHASE_W-1:0]       tx_ph_r;
    logic [FRAME_BITS-1:0]    rx_sh_r, tx_sh_r, frame;
    logic                     instr_pend_r, resync_r;
    logic                     agree, fall, tick, brk_hit, restart, s_bit, s_done;
    logic [PER_W:0]           acc_sum;

    // ----------------------------------------------------------------------
    // pin synchroniser: a change counts once stages two and three agree
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_r   <= 3'h7;
            line_f_r <= 1'b1;
        end else begin
            sync_r <= {sync_r[1:0], line_in};
            if (agree) line_f_r <= sync_r[2];
        end
    end
    assign agree = (sync_r[1] == sync_r[2]);
    assign fall  = agree && line_f_r && !sync_r[2];

    // ----------------------------------------------------------------------
    // fractional sample tick: 128 sixteenth-bits per measured 8-bit span
    // ----------------------------------------------------------------------
    assign acc_sum = {1'b0, acc_r} + (PER_W+1)'(FRAC_STEP);
    assign tick    = baud_locked_out && (acc_sum >= {1'b0, period_r});
    assign restart = (state_r == ST_IDLE) && (fall || (tx_valid_in && tx_ready_out));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_r <= '0;
        end else if (brk_hit || restart) begin
            acc_r <= '0;
        end else if (tick) begin
            acc_r <= PER_W'(acc_sum - {1'b0, period_r});
        end else if (baud_locked_out) begin
            acc_r <= PER_W'(acc_sum);
        end
    end

    // ----------------------------------------------------------------------
    // break: line low longer than a whole frame (12 bits = 1.5 sync spans)
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) low_r <= '0;
        else if (line_f_r || brk_hit) low_r <= '0;
        else low_r <= low_r + 32'h1;
    end
    // own frames hold the line low for ten bits at most, so no self-break
    assign brk_hit = !line_f_r && (baud_locked_out
                   ? (low_r >= 32'(period_r) + 32'(period_r >> 1))
                   : (low_r >= BREAK_CYC));

    sdu_bit_sampler u_sampler (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .restart_in (restart || brk_hit),
        .tick_in    (tick && state_r == ST_RX),
        .line_in    (line_f_r),
        .bit_out    (s_bit),
        .done_out   (s_done)
    );
    assign frame = {s_bit, rx_sh_r[FRAME_BITS-1:1]};

    // ----------------------------------------------------------------------
    // main sequence: sync measure, receive, transmit
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r         <= ST_SYNC;
            meas_r          <= '0;
            period_r        <= '0;
            falls_r         <= 3'h0;
            tail_r          <= '0;
            baud_locked_out <= 1'b0;
            bit_idx_r       <= '0;
            tx_ph_r         <= '0;
            rx_sh_r         <= '1;
            tx_sh_r         <= '1;
        end else if (brk_hit) begin
            state_r         <= ST_SYNC;
            baud_locked_out <= 1'b0;
        end else begin
            unique case (state_r)
                ST_SYNC: if (fall) begin
                    meas_r  <= '0;
                    falls_r <= 3'h0;
                    state_r <= ST_SYNC_MEAS;
                end
                ST_SYNC_MEAS: begin
                    meas_r <= meas_r + PER_W'(1);
                    if (&meas_r) begin
                        state_r <= ST_SYNC;
                    end else if (fall) begin
                        falls_r <= falls_r + 3'h1;
                        if (falls_r == 3'(SYNC_FALLS - 1)) begin
                            period_r <= meas_r + PER_W'(1);
                            if (meas_r + PER_W'(1) < PER_W'(FRAC_STEP)) begin
                                state_r <= ST_SYNC;   // too fast to divide
                            end else begin
                                baud_locked_out <= 1'b1;
                                tail_r          <= '0;
                                state_r         <= ST_SYNC_TAIL;
                            end
                        end
                    end
                end
                ST_SYNC_TAIL: if (tick) begin
                    tail_r <= tail_r + SYNC_TAIL_W'(1);
                    if (tail_r == SYNC_TAIL_W'(SYNC_TAIL_TICKS - 1)) state_r <= ST_IDLE;
                end
                ST_IDLE: begin
                    bit_idx_r <= '0;
                    tx_ph_r   <= '0;
                    if (fall) begin
                        state_r <= ST_RX;
                    end else if (resync_r) begin
                        state_r <= ST_SYNC;
                    end else if (tx_valid_in && tx_ready_out) begin
                        tx_sh_r <= {2'b11, ^tx_data_in, tx_data_in, 1'b0};
                        state_r <= ST_TX;
                    end
                end
                ST_RX: if (s_done) begin
                    rx_sh_r   <= frame;
                    bit_idx_r <= bit_idx_r + BIT_IDX_W'(1);
                    if (bit_idx_r == BIT_IDX_W'(FRAME_BITS - 1)) state_r <= ST_IDLE;
                end
                ST_TX: if (tick) begin
                    tx_ph_r <= tx_ph_r + PHASE_W'(1);
                    if (tx_ph_r == PHASE_W'(SAMPLES_PER_BIT - 1)) begin
                        tx_sh_r   <= {1'b1, tx_sh_r[FRAME_BITS-1:1]};
                        bit_idx_r <= bit_idx_r + BIT_IDX_W'(1);
                        if (bit_idx_r == BIT_IDX_W'(FRAME_BITS - 1)) state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // line driver and transmit handshake
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            line_out      <= 1'b1;
            line_oe_n_out <= 1'b1;
            tx_ready_out  <= 1'b0;
            break_out     <= 1'b0;
        end else begin
            line_out      <= (state_r == ST_TX) ? tx_sh_r[0] : 1'b1;
            line_oe_n_out <= !(state_r == ST_TX) || brk_hit;
            tx_ready_out  <= (state_r == ST_IDLE) && !fall && !resync_r
                          && !(tx_valid_in && tx_ready_out) && !brk_hit;
            break_out     <= brk_hit;
        end
    end

    // ----------------------------------------------------------------------
    // received byte, frame check, instruction decode
    // ----------------------------------------------------------------------
    function automatic sdu_instr_t decode(input logic [7:0] b);
        sdu_instr_t d;
        d.opcode          = sdu_opcode_t'(b[7:5]);
        d.size_a          = sdu_size_t'(b[3:2]);
        d.ptr             = sdu_ptr_t'(b[3:2]);
        d.size_b          = sdu_size_t'(b[1:0]);
        d.cs_addr         = b[3:0];
        d.cs_access_layer = (b[3:0] == CS_ACCESS_LAYER);
        d.key_size        = sdu_key_size_t'(b[1:0]);
        d.key_bytes       = (b[1:0] == 2'(KEY_128)) ? KEY_BYTES_128 : KEY_BYTES_64;
        d.sib_send        = b[2];
        unique case (d.opcode)
            OP_DIRECT_LOAD, OP_DIRECT_STORE:
                d.reserved = d.size_a[1] || d.size_b[1];
            OP_INDIRECT_LOAD, OP_INDIRECT_STORE:
                d.reserved = (d.ptr == PTR_RSV) || d.size_b[1];
            OP_REPEAT:
                d.reserved = d.size_b[1];
            OP_CTRL_STATUS_LOAD, OP_CTRL_STATUS_STORE:
                d.reserved = (b[3:0] > CS_ACCESS_LAYER) || (b[3:0] == CS_RESERVED);
            OP_KEY:
                d.reserved = d.key_size[1];
        endcase
        return d;
    endfunction : decode

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_valid_out    <= 1'b0;
            rx_data_out     <= 8'h00;
            rx_error_out    <= 1'b0;
            instr_valid_out <= 1'b0;
            instr_out       <= '0;
            sib_req_out     <= 1'b0;
            instr_pend_r    <= 1'b0;
            resync_r        <= 1'b0;
        end else if (brk_hit) begin
            rx_valid_out    <= 1'b0;
            instr_valid_out <= 1'b0;
            sib_req_out     <= 1'b0;
            instr_pend_r    <= 1'b0;
            resync_r        <= 1'b0;
        end else begin
            rx_valid_out    <= 1'b0;
            instr_valid_out <= 1'b0;
            sib_req_out     <= 1'b0;
            // a new sync is needed once the caller says the instruction is done
            if (resync_in) resync_r <= 1'b1;
            else if (state_r == ST_SYNC) resync_r <= 1'b0;
            if (state_r == ST_SYNC_TAIL) instr_pend_r <= 1'b1;
            if (state_r == ST_RX && s_done && bit_idx_r == BIT_IDX_W'(FRAME_BITS - 1)) begin
                rx_valid_out <= 1'b1;
                rx_data_out  <= frame[8:1];
                rx_error_out <= frame[0] || (^frame[9:1]) || !(&frame[11:10]);
                if (instr_pend_r) begin
                    instr_pend_r    <= 1'b0;
                    instr_valid_out <= 1'b1;
                    instr_out       <= decode(frame[8:1]);
                    sib_req_out     <= (frame[8:6] == 3'(OP_KEY)) && frame[3];
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // debug clock select; reserved code 0 is ignored on write
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            debug_clock_select_out <= CLKSEL_RESET;
            debug_clock_mhz_out    <= MHZ_4;
            baud_period_out        <= '0;
        end else begin
            baud_period_out <= period_r;
            if (brk_hit) begin
                debug_clock_select_out <= CLKSEL_RESET;
                debug_clock_mhz_out    <= MHZ_4;
            end else if (clk_sel_wr_in && clk_sel_in != 2'h0) begin
                debug_clock_select_out <= clk_sel_in;
                debug_clock_mhz_out    <= (clk_sel_in == CLKSEL_16MHZ) ? MHZ_16 :
                                          (clk_sel_in == CLKSEL_8MHZ)  ? MHZ_8 : MHZ_4;
            end
        end
    end
endmodule : sdu_port

// >>> tb/sdu_port_chk.sv
// concurrent checks on the ports of the debug port, bound into sdu_port
`timescale 1ns/100ps
module sdu_port_chk
    import sdu_pkg::*;
#(
    parameter int          PER_W     = 24,
    parameter logic [31:0] BREAK_CYC = 32'd20000000
)(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             line_out,
    input  wire logic             line_oe_n_out,
    input  wire logic             clk_sel_wr_in,
    input  wire logic [1:0]       clk_sel_in,
    input  wire logic             tx_valid_in,
    input  wire logic             tx_ready_out,
    input  wire logic             rx_valid_out,
    input  wire logic             instr_valid_out,
    input  wire sdu_instr_t       instr_out,
    input  wire logic             sib_req_out,
    input  wire logic             baud_locked_out,
    input  wire logic [PER_W-1:0] baud_period_out,
    input  wire logic [1:0]       debug_clock_select_out,
    input  wire logic [7:0]       debug_clock_mhz_out
);
    // ----------------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // start bit after a taken byte
    sequence tx_taken_s; tx_valid_in && tx_ready_out; endsequence
    sequence start_bit_s; !line_oe_n_out && !line_out; endsequence
    tx_start_a: assert property (tx_taken_s |=> ##1 start_bit_s [*8])
        else $error("no start bit");
    sel_load_a: assert property (clk_sel_wr_in && clk_sel_in != 2'h0 |=>
        debug_clock_select_out == $past(clk_sel_in)) else $error("select not loaded");
    sel_keep_a: assert property (clk_sel_wr_in && clk_sel_in == 2'h0 |=>
        $stable(debug_clock_select_out)) else $error("code zero loaded");
    // rate follows a settled code
    mhz_map_a: assert property ($stable(debug_clock_select_out) |-> debug_clock_mhz_out ==
        (debug_clock_select_out == CLKSEL_16MHZ ? MHZ_16 :
         debug_clock_select_out == CLKSEL_8MHZ ? MHZ_8 : MHZ_4)) else $error("rate mismatch");
    rx_pulse_a: assert property (rx_valid_out |=> !rx_valid_out)
        else $error("rx strobe too long");
    half_dup_a: assert property (!line_oe_n_out |-> !rx_valid_out)
        else $error("byte received while transmitting");
    sib_map_a: assert property (sib_req_out |-> instr_out.opcode == OP_KEY &&
        instr_out.sib_send) else $error("bad info request");
    cs_layer_a: assert property (instr_valid_out && instr_out.opcode == OP_CTRL_STATUS_LOAD |->
        instr_out.cs_access_layer == (instr_out.cs_addr == CS_ACCESS_LAYER))
        else $error("access layer flag wrong");
    key_len_a: assert property (instr_valid_out && instr_out.opcode == OP_KEY &&
        instr_out.key_size == KEY_128 |-> instr_out.key_bytes == KEY_BYTES_128)
        else $error("key length wrong");
    lock_min_a: assert property ($rose(baud_locked_out) |=> baud_period_out >= 128)
        else $error("short period lock");
endmodule : sdu_port_chk

bind sdu_port sdu_port_chk #(.PER_W(PER_W), .BREAK_CYC(BREAK_CYC)) sdu_port_chk_i (.*);

// >>> tb/sdu_dbg_model.sv
// behavioural debugger at the far end of the wire: sends frames, reads replies
`timescale 1ns/100ps
module sdu_dbg_model (
    input  wire logic  clk_in,
    input  wire logic  line_in,
    output logic       drive_out,
    output logic       got_valid_out,
    output logic [7:0] got_data_out,
    output logic       got_ok_out
);
    logic        sending = 1'b0;
    int          bitc    = 32;
    logic [11:0] fr_r;
    // released wire reads high
    initial begin
        drive_out     = 1'b1;
        got_valid_out = 1'b0;
        got_data_out  = 8'h00;
        got_ok_out    = 1'b0;
    end
    // one frame, lsb first, even parity; glitch flips one clock near mid bit
    task automatic send_byte(input logic [7:0] d, input int bc, input logic bad_par,
                             input logic glitch);
        logic [11:0] fr;
        fr = {2'b11, ^d ^ bad_par, d, 1'b0};
        sending = 1'b1;
        bitc = bc;
        for (int b = 0; b < 12; b++) begin
            for (int c = 0; c < bc; c++) begin
                @(posedge clk_in);
                #1 drive_out = (glitch && c == bc / 2 - 2) ? ~fr[b] : fr[b];
            end
        end
        sending = 1'b0;
    endtask : send_byte
    // long low level
    task automatic send_break(input int n);
        sending = 1'b1;
        @(posedge clk_in);
        #1 drive_out = 1'b0;
        repeat (n) @(posedge clk_in);
        #1 drive_out = 1'b1;
        sending = 1'b0;
    endtask : send_break
    // read a reply at the last rate, mid bit
    always begin
        @(negedge line_in);
        if (!sending) begin
            repeat (bitc / 2) @(posedge clk_in);
            for (int b = 0; b < 12; b++) begin
                fr_r[b] = line_in;
                if (b < 11) repeat (bitc) @(posedge clk_in);
            end
            got_data_out  = fr_r[8:1];
            got_ok_out    = !fr_r[0] && !(^fr_r[9:1]) && fr_r[11:10] == 2'b11;
            got_valid_out = 1'b1;
            #1 got_valid_out = 1'b0;
        end
    end
endmodule : sdu_dbg_model

// >>> tb/tb_sdu_port.sv
// self-checking bench for the one-wire debug port
`timescale 1ns/100ps
module tb_sdu_port;
    import sdu_pkg::*;
    localparam int BITC = 32;
    logic clk_in = 1'b0, rst_in = 1'b1, clk_sel_wr_in = 1'b0, tx_valid_in = 1'b0;
    logic [1:0] clk_sel_in = 2'h0;
    logic resync_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00, rx_data_out, got_data, b, mhz;
    logic line_w, drive, line_out, line_oe_n_out, tx_ready_out, rx_valid_out, rx_error_out;
    logic instr_valid_out, sib_req_out, baud_locked_out, break_out, got_valid, got_ok;
    logic [23:0] baud_period_out;
    logic [1:0]  debug_clock_select_out, e_sel;
    logic [7:0]  debug_clock_mhz_out;
    sdu_instr_t  instr_out;
    logic [7:0]  rx_q[$], ins_q[$], tx_q[$];
    int errors = 0, checked = 0, seed, n;
    always #4 clk_in = ~clk_in;
    // pull-up; either side pulls low
    assign line_w = drive & (line_oe_n_out | line_out);
    sdu_port #(.PER_W(24), .BREAK_CYC(32'd2000)) sdu_port_i (.*, .line_in(line_w));
    sdu_dbg_model sdu_dbg_model_i (.clk_in(clk_in), .line_in(line_w), .drive_out(drive),
        .got_valid_out(got_valid), .got_data_out(got_data), .got_ok_out(got_ok));
    // ----------------------------------------------------------------------
    // compare and stimulus tasks
    // ----------------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask : chk_val
    // only the fields that the opcode gives meaning to are compared
    task automatic chk_instr(input logic [7:0] v);
        chk_val(32'(instr_out.opcode), 32'(v[7:5]), "opcode");
        if (v[7:5] inside {3'h0, 3'h2}) chk_val(32'(instr_out.size_a), 32'(v[3:2]), "size a");
        if (v[7:5] inside {3'h1, 3'h3}) chk_val(32'(instr_out.ptr), 32'(v[3:2]), "pointer");
        if (v[7:5] < 3'h4) chk_val(32'(instr_out.size_b), 32'(v[1:0]), "size b");
        if (v[7:5] inside {3'h4, 3'h6}) chk_val(32'(instr_out.cs_addr), 32'(v[3:0]), "cs");
        if (v[7:5] == 3'h7) chk_val(32'(instr_out.sib_send), 32'(v[2]), "info sel");
        if (v[7:5] == 3'h7) chk_val(32'(instr_out.key_size), 32'(v[1:0]), "key size");
    endtask : chk_instr
    task automatic instr(input logic [7:0] v, input logic gl);
        @(posedge clk_in);
        #1 resync_in = 1'b1;
        @(posedge clk_in);
        #1 resync_in = 1'b0;
        sdu_dbg_model_i.send_byte(8'h55, BITC, 1'b0, 1'b0);
        ins_q.push_back(v);
        rx_q.push_back(v);
        sdu_dbg_model_i.send_byte(v, BITC, 1'b0, gl);
    endtask : instr
    task automatic set_sel(input logic [1:0] c);
        @(posedge clk_in);
        #1 clk_sel_wr_in = 1'b1;
        clk_sel_in = c;
        @(posedge clk_in);
        #1 clk_sel_wr_in = 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : set_sel
    // hold valid until taken with ready
    task automatic send_tx(input logic [7:0] d);
        @(posedge clk_in);
        #1 tx_valid_in = 1'b1;
        tx_data_in = d;
        tx_q.push_back(d);
        for (n = 0; n < 9000 && tx_ready_out !== 1'b1; n++) @(posedge clk_in) #1;
        @(posedge clk_in);
        #1 tx_valid_in = 1'b0;
    endtask : send_tx
    task final_report;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    // match results against the oldest note
    always @(posedge clk_in) begin
        if (rx_valid_out === 1'b1 && rx_error_out !== 1'b1)
            chk_val(32'(rx_data_out), 32'(rx_q.pop_front()), "rx byte");
        if (instr_valid_out === 1'b1) chk_instr(ins_q.pop_front());
        if (break_out === 1'b1) chk_val(32'(drive), 32'h0, "break line");
    end
    always @(posedge got_valid) begin
        chk_val(32'(got_data), 32'(tx_q.pop_front()), "tx byte");
        chk_val(32'(got_ok), 32'h1, "tx framing");
    end
    // watchdog: the whole sequence needs about 18000 cycles
    initial begin
        #480000;
        errors++;
        $display("Error at %0t: timeout", $time);
        final_report;
    end
    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial begin
        seed = $urandom(25560);
        repeat (6) @(posedge clk_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        chk_val(32'(debug_clock_select_out), 32'(CLKSEL_RESET), "reset select");
        chk_val(32'(debug_clock_mhz_out), 32'(MHZ_4), "reset rate");
        e_sel = 2'h3;
        for (int i = 0; i < 4; i++) begin
            b = {6'h00, 2'(8'hc9 >> (2 * i))};
            set_sel(b[1:0]);
            if (b[1:0] != 2'h0) e_sel = b[1:0];
            mhz = e_sel == 2'h1 ? 8'h10 : e_sel == 2'h2 ? 8'h08 : 8'h04;
            chk_val(32'(debug_clock_select_out), 32'(e_sel), "select");
            chk_val(32'(debug_clock_mhz_out), 32'(mhz), "rate");
        end
        for (int k = 0; k < 16; k++) begin
            b = {3'(k), 5'($urandom)};
            if (k == 4) b[4:0] = 5'h04;
            if (k == 7) b[4:0] = 5'h05;
            instr(b, k >= 8);
            chk_val(32'(baud_period_out), 32'(8 * BITC), "period");
        end
        instr(8'h44, 1'b0);
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            rx_q.push_back(b);
            sdu_dbg_model_i.send_byte(b, BITC + 1, 1'b0, 1'b0);
        end
        repeat (40) @(posedge clk_in);
        for (int k = 0; k < 3; k++) send_tx(8'($urandom));
        for (n = 0; n < 20000 && tx_q.size() != 0; n++) @(posedge clk_in);
        instr(8'h40, 1'b0);
        sdu_dbg_model_i.send_byte(8'h3c, BITC, 1'b1, 1'b0);
        repeat (40) @(posedge clk_in);
        chk_val(32'(rx_error_out), 32'h1, "parity fault");
        set_sel(2'h1);
        sdu_dbg_model_i.send_break(600);
        repeat (20) @(posedge clk_in);
        chk_val(32'(baud_locked_out), 32'h0, "lock after break");
        chk_val(32'(debug_clock_select_out), 32'(CLKSEL_RESET), "select after break");
        instr(8'hff, 1'b0);
        repeat (40) @(posedge clk_in);
        chk_val(32'(baud_locked_out), 32'h1, "relock");
        chk_val(32'(rx_q.size() + ins_q.size() + tx_q.size()), 32'h0, "pending notes");
        final_report;
    end
endmodule : tb_sdu_port
